// ==== common/acfg_pkg.sv ====
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package acfg_pkg;

   //---------------------------------------------------------------------------
   // Register addresses and reset values.
   //---------------------------------------------------------------------------
   localparam logic [7:0] ACFG_MODE_ADDR = 8'h02;   // Operating mode control.
   localparam logic [7:0] ACFG_CLOCK_ADDR = 8'h03;  // Clock and channel control.
   localparam logic [7:0] ACFG_GAIN_ADDR = 8'h04;   // Amplifier gain select.
   localparam logic [7:0] ACFG_CFG_ADDR = 8'h06;    // Global settings.
   localparam logic [15:0] ACFG_MODE_RST = 16'h0510;
   localparam logic [15:0] ACFG_CLOCK_RST = 16'h070e;
   localparam logic [15:0] ACFG_GAIN_RST = 16'h0000;
   localparam logic [15:0] ACFG_CFG_RST = 16'h0600;

   // Writable bits; everything else is reserved and held at zero.
   localparam logic [15:0] ACFG_MODE_MASK = 16'h3f1f;
   localparam logic [15:0] ACFG_CLOCK_MASK = 16'h07ff;
   localparam logic [15:0] ACFG_GAIN_MASK = 16'h0777;
   localparam logic [15:0] ACFG_CFG_MASK = 16'h7f00;

   //---------------------------------------------------------------------------
   // Field positions.
   //---------------------------------------------------------------------------
   localparam int ACFG_REG_CRC_BIT = 13;
   localparam int ACFG_RX_CRC_BIT = 12;
   localparam int ACFG_CRC_TYPE_BIT = 11;
   localparam int ACFG_RESET_BIT = 10;
   localparam int ACFG_WORD_LSB = 8;
   localparam int ACFG_TIMEOUT_BIT = 4;
   localparam int ACFG_SRC_LSB = 2;
   localparam int ACFG_FLOAT_BIT = 1;
   localparam int ACFG_PULSE_BIT = 0;
   localparam int ACFG_CHEN_LSB = 8;
   localparam int ACFG_DIV_LSB = 6;
   localparam int ACFG_TURBO_BIT = 5;
   localparam int ACFG_OSR_LSB = 2;
   localparam int ACFG_PWR_LSB = 0;
   localparam int ACFG_GAIN0_LSB = 0;
   localparam int ACFG_GAIN1_LSB = 4;
   localparam int ACFG_GAIN2_LSB = 8;
   localparam int ACFG_DIGITAL_OUT_ENABLE_BIT = 14;
   localparam int ACFG_DIGITAL_OUT_LEVEL_BIT = 13;
   localparam int ACFG_DLY_LSB = 9;
   localparam int ACFG_CHOP_BIT = 8;

   //---------------------------------------------------------------------------
   // Timing.
   //---------------------------------------------------------------------------
   localparam int ACFG_CLK_NS = 25;          // System clock period.
   localparam int ACFG_PULSE_NS = 100;       // Ready pulse low time, least.
   localparam int ACFG_PULSE_CYC = (ACFG_PULSE_NS + ACFG_CLK_NS - 1) / ACFG_CLK_NS;
   localparam logic [14:0] ACFG_TURBO_RATIO = 15'h0040;
   localparam logic [14:0] ACFG_BASE_RATIO = 15'h0080;

   // Ready pin states, Gray coded along idle, level, pulse.
   typedef enum logic [1:0] {
      ACFG_RDY_IDLE = 2'b00,
      ACFG_RDY_LEVEL = 2'b01,
      ACFG_RDY_PULSE = 2'b11
   } acfg_rdy_state_t;

endpackage

// ==== core/acfg_ready_pin.sv ====
`timescale 1ns/1ps
module acfg_ready_pin
   import acfg_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Configuration.
   input wire logic [2:0] channel_enable_i,
   input wire logic [1:0] ready_source_select_i,
   input wire logic ready_idle_float_i,
   input wire logic ready_pulse_format_i,
   // Conversion events.
   input wire logic [2:0] chan_ready_i,
   input wire logic data_read_i,
   // Pin and status.
   output logic data_ready_pin_o,
   output logic data_ready_pin_oe_o,
   output logic [2:0] pending_o
);

   //---------------------------------------------------------------------------
   // State.
   //---------------------------------------------------------------------------
   acfg_rdy_state_t state, next_state;   // Pin sequencer.
   logic [2:0] pending, next_pending;    // Per-channel new-data flags.
   logic [2:0] pulse_cnt, next_pulse_cnt; // Pulse low-time counter.
   logic active, next_active;            // Selected source asserted last cycle.
   logic next_pin, next_oe;
   logic cond;                           // Selected source condition.
   logic trigger;                        // Event that starts a pulse.

   //---------------------------------------------------------------------------
   // Next-state logic.
   //---------------------------------------------------------------------------
   always_comb begin
      // A new sample beats a concurrent read so no conversion goes unseen.
      next_pending = (data_read_i ? 3'b000 : pending) | (chan_ready_i & channel_enable_i);
      unique case (ready_source_select_i)
         2'b00: begin
            // Lagging: wait until every enabled channel has data.
            cond = (|channel_enable_i) && (&(pending | ~channel_enable_i));
         end
         default: begin
            cond = |(pending & channel_enable_i);
         end
      endcase
      next_active = cond;
      // The OR source retriggers on every arrival; the others when their condition rises.
      if (ready_source_select_i == 2'b01) begin
         trigger = |(chan_ready_i & channel_enable_i);
      end else begin
         trigger = cond && !active;
      end
      next_state = state;
      next_pulse_cnt = pulse_cnt;
      unique case (state)
         ACFG_RDY_IDLE: begin
            if (ready_pulse_format_i && trigger) begin
               next_state = ACFG_RDY_PULSE;
               next_pulse_cnt = 3'(ACFG_PULSE_CYC - 1);
            end else if (!ready_pulse_format_i && cond) begin
               next_state = ACFG_RDY_LEVEL;
            end
         end
         ACFG_RDY_LEVEL: begin
            if (!cond || ready_pulse_format_i) begin
               next_state = ACFG_RDY_IDLE;
            end
         end
         ACFG_RDY_PULSE: begin
            // The pulse length is fixed; it does not stretch for late data.
            if (pulse_cnt == 3'h0) begin
               next_state = ACFG_RDY_IDLE;
            end else begin
               next_pulse_cnt = pulse_cnt - 3'h1;
            end
         end
         default: begin
            next_state = ACFG_RDY_IDLE;
         end
      endcase
      // Drive low whenever asserting; idle is high or floating.
      next_pin = (next_state == ACFG_RDY_IDLE);
      next_oe = (next_state != ACFG_RDY_IDLE) || !ready_idle_float_i;
   end

   //---------------------------------------------------------------------------
   // Registers.
   //---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ACFG_RDY_IDLE;
         pending <= 3'h0;
         pulse_cnt <= 3'h0;
         active <= 1'b0;
         data_ready_pin_o <= 1'b1;
         data_ready_pin_oe_o <= 1'b1;
      end else begin
         state <= next_state;
         pending <= next_pending;
         pulse_cnt <= next_pulse_cnt;
         active <= next_active;
         data_ready_pin_o <= next_pin;
         data_ready_pin_oe_o <= next_oe;
      end
   end

   assign pending_o = pending;

   //---------------------------------------------------------------------------
   // Checks.
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_pulse_start;
      state == ACFG_RDY_IDLE && next_state == ACFG_RDY_PULSE;
   endsequence

   a_pulse_low_width: assert property (
      s_pulse_start |=> (!data_ready_pin_o && data_ready_pin_oe_o) [*4] ##1 data_ready_pin_o)
      else $error("Ready pulse width wrong.");

   a_idle_float_pin: assert property (
      (next_state == ACFG_RDY_IDLE && ready_idle_float_i) |=> !data_ready_pin_oe_o)
      else $error("Idle ready pin not floating.");

   a_level_follows: assert property (
      (state == ACFG_RDY_IDLE && !ready_pulse_format_i && cond) |=>
         !data_ready_pin_o && data_ready_pin_oe_o)
      else $error("Static ready level not driven low.");

endmodule

// ==== core/acfg_regs.sv ====
`timescale 1ns/1ps
module acfg_regs
   import acfg_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register access from the serial frame decoder.
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wr_data_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   // CRC and frame controls.
   output logic reg_crc_en_o,
   output logic rx_crc_en_o,
   output logic crc_ansi_o,
   output logic reset_flag_clear_o,
   output logic [1:0] word_size_select_o,
   output logic timeout_en_o,
   // Converter controls.
   output logic [2:0] channel_enable_o,
   output logic mod_clk_en_o,
   output logic [14:0] oversampling_ratio_o,
   output logic [1:0] power_profile_o,
   output logic [7:0] amp_gain_channel_zero_o,
   output logic [7:0] amp_gain_channel_one_o,
   output logic [7:0] amp_gain_channel_two_o,
   // Global chop.
   input wire logic chop_start_i,
   output logic chop_enable_o,
   output logic chop_done_o,
   // Digital output pin.
   output logic digital_out_o,
   output logic digital_out_oe_o,
   // Data-ready pin.
   input wire logic [2:0] chan_ready_i,
   input wire logic data_read_i,
   output logic data_ready_pin_o,
   output logic data_ready_pin_oe_o
);

   //---------------------------------------------------------------------------
   // Helper functions.
   //---------------------------------------------------------------------------
   // Gain factor two to the code.
   function automatic logic [7:0] gain_factor(input logic [2:0] code);
      gain_factor = 8'h01 << code;
   endfunction

   // Divider terminal count, one less than the ratio.
   function automatic logic [3:0] div_last(input logic [1:0] code);
      unique case (code)
         2'b00: div_last = 4'h1;
         2'b01: div_last = 4'h3;
         2'b10: div_last = 4'h7;
         default: div_last = 4'hb;
      endcase
   endfunction

   //---------------------------------------------------------------------------
   // Register file.
   //---------------------------------------------------------------------------
   logic [15:0] operating_mode_control, next_mode;
   logic [15:0] clock_and_channel_control, next_clock;
   logic [15:0] amplifier_gain_select, next_gain;
   logic [15:0] global_settings, next_cfg;
   logic [15:0] next_rd_data;
   logic next_rd_valid, next_reset_clear;

   // Decodes host accesses. Reserved bits are masked off on write so that
   // readback always shows them as zero.
   always_comb begin
      next_mode = operating_mode_control;
      next_clock = clock_and_channel_control;
      next_gain = amplifier_gain_select;
      next_cfg = global_settings;
      next_reset_clear = 1'b0;
      next_rd_valid = rd_en_i;
      next_rd_data = 16'h0000;
      if (wr_en_i) begin
         if (addr_i == ACFG_MODE_ADDR) begin
            next_mode = wr_data_i & ACFG_MODE_MASK;
            // Writing zero to the reset bit clears the status flag.
            next_reset_clear = !wr_data_i[ACFG_RESET_BIT];
         end else if (addr_i == ACFG_CLOCK_ADDR) begin
            // Reserved power codes are stored as written; the host avoids them.
            next_clock = wr_data_i & ACFG_CLOCK_MASK;
         end else if (addr_i == ACFG_GAIN_ADDR) begin
            next_gain = wr_data_i & ACFG_GAIN_MASK;
         end else if (addr_i == ACFG_CFG_ADDR) begin
            next_cfg = wr_data_i & ACFG_CFG_MASK;
         end
      end
      // Unmapped reads return zero.
      if (rd_en_i) begin
         if (addr_i == ACFG_MODE_ADDR) begin
            next_rd_data = operating_mode_control;
         end else if (addr_i == ACFG_CLOCK_ADDR) begin
            next_rd_data = clock_and_channel_control;
         end else if (addr_i == ACFG_GAIN_ADDR) begin
            next_rd_data = amplifier_gain_select;
         end else if (addr_i == ACFG_CFG_ADDR) begin
            next_rd_data = global_settings;
         end
      end
   end

   // Stores the registers. The reset bit comes up set after every reset.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         operating_mode_control <= ACFG_MODE_RST;
         clock_and_channel_control <= ACFG_CLOCK_RST;
         amplifier_gain_select <= ACFG_GAIN_RST;
         global_settings <= ACFG_CFG_RST;
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
         reset_flag_clear_o <= 1'b0;
      end else begin
         operating_mode_control <= next_mode;
         clock_and_channel_control <= next_clock;
         amplifier_gain_select <= next_gain;
         global_settings <= next_cfg;
         rd_data_o <= next_rd_data;
         rd_valid_o <= next_rd_valid;
         reset_flag_clear_o <= next_reset_clear;
      end
   end

   // Plain controls come straight from the register flops.
   assign reg_crc_en_o = operating_mode_control[ACFG_REG_CRC_BIT];
   assign rx_crc_en_o = operating_mode_control[ACFG_RX_CRC_BIT];
   assign crc_ansi_o = operating_mode_control[ACFG_CRC_TYPE_BIT];
   assign word_size_select_o = operating_mode_control[ACFG_WORD_LSB +: 2];
   assign timeout_en_o = operating_mode_control[ACFG_TIMEOUT_BIT];
   assign channel_enable_o = clock_and_channel_control[ACFG_CHEN_LSB +: 3];
   assign power_profile_o = clock_and_channel_control[ACFG_PWR_LSB +: 2];
   assign chop_enable_o = global_settings[ACFG_CHOP_BIT];

   //---------------------------------------------------------------------------
   // Modulator clock divider and derived settings.
   //---------------------------------------------------------------------------
   logic [3:0] div_cnt, next_div_cnt;
   logic next_mod_en;
   logic [14:0] next_ratio;
   logic next_gpo, next_gpo_oe;

   // A shrinking ratio restarts the count so the divider never runs away.
   always_comb begin
      next_mod_en = 1'b0;
      if (div_cnt >= div_last(clock_and_channel_control[ACFG_DIV_LSB +: 2])) begin
         next_div_cnt = 4'h0;
         next_mod_en = 1'b1;
      end else begin
         next_div_cnt = div_cnt + 4'h1;
      end
      if (clock_and_channel_control[ACFG_TURBO_BIT]) begin
         next_ratio = ACFG_TURBO_RATIO;
      end else begin
         next_ratio = ACFG_BASE_RATIO << clock_and_channel_control[ACFG_OSR_LSB +: 3];
      end
      next_gpo_oe = global_settings[ACFG_DIGITAL_OUT_ENABLE_BIT];
      next_gpo = global_settings[ACFG_DIGITAL_OUT_ENABLE_BIT] && global_settings[ACFG_DIGITAL_OUT_LEVEL_BIT];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_cnt <= 4'h0;
         mod_clk_en_o <= 1'b0;
         oversampling_ratio_o <= 15'h0400;
         amp_gain_channel_zero_o <= 8'h01;
         amp_gain_channel_one_o <= 8'h01;
         amp_gain_channel_two_o <= 8'h01;
         digital_out_o <= 1'b0;
         digital_out_oe_o <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         mod_clk_en_o <= next_mod_en;
         oversampling_ratio_o <= next_ratio;
         amp_gain_channel_zero_o <= gain_factor(amplifier_gain_select[ACFG_GAIN0_LSB +: 3]);
         amp_gain_channel_one_o <= gain_factor(amplifier_gain_select[ACFG_GAIN1_LSB +: 3]);
         amp_gain_channel_two_o <= gain_factor(amplifier_gain_select[ACFG_GAIN2_LSB +: 3]);
         digital_out_o <= next_gpo;
         digital_out_oe_o <= next_gpo_oe;
      end
   end

   //---------------------------------------------------------------------------
   // Global-chop settle delay.
   //---------------------------------------------------------------------------
   logic [16:0] chop_cnt, next_chop_cnt;
   logic chop_busy, next_chop_busy;
   logic next_chop_done;

   // Counts modulator periods; with chop off measurement starts at once.
   always_comb begin
      next_chop_cnt = chop_cnt;
      next_chop_busy = chop_busy;
      next_chop_done = 1'b0;
      if (chop_start_i) begin
         if (global_settings[ACFG_CHOP_BIT]) begin
            next_chop_busy = 1'b1;
            next_chop_cnt = 17'h0_0002 << global_settings[ACFG_DLY_LSB +: 4];
         end else begin
            next_chop_done = 1'b1;
         end
      end else if (chop_busy && mod_clk_en_o) begin
         next_chop_cnt = chop_cnt - 17'h0_0001;
         if (chop_cnt == 17'h0_0001) begin
            next_chop_busy = 1'b0;
            next_chop_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chop_cnt <= 17'h0_0000;
         chop_busy <= 1'b0;
         chop_done_o <= 1'b0;
      end else begin
         chop_cnt <= next_chop_cnt;
         chop_busy <= next_chop_busy;
         chop_done_o <= next_chop_done;
      end
   end

   //---------------------------------------------------------------------------
   // Data-ready pin driver.
   //---------------------------------------------------------------------------
   acfg_ready_pin u_ready_pin (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .channel_enable_i(channel_enable_o),
      .ready_source_select_i(operating_mode_control[ACFG_SRC_LSB +: 2]),
      .ready_idle_float_i(operating_mode_control[ACFG_FLOAT_BIT]),
      .ready_pulse_format_i(operating_mode_control[ACFG_PULSE_BIT]),
      .chan_ready_i(chan_ready_i),
      .data_read_i(data_read_i),
      .data_ready_pin_o(data_ready_pin_o),
      .data_ready_pin_oe_o(data_ready_pin_oe_o),
      .pending_o()
   );

   //---------------------------------------------------------------------------
   // Checks.
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_mode_write;
      wr_en_i && addr_i == ACFG_MODE_ADDR;
   endsequence

   a_reset_flag_clear: assert property (
      (s_mode_write and !wr_data_i[ACFG_RESET_BIT]) |=>
         reset_flag_clear_o && !operating_mode_control[ACFG_RESET_BIT])
      else $error("Reset flag clear not issued.");

   a_mode_write_lands: assert property (
      s_mode_write |=> operating_mode_control == ($past(wr_data_i) & ACFG_MODE_MASK) &&
         reg_crc_en_o == $past(wr_data_i[ACFG_REG_CRC_BIT]) &&
         rx_crc_en_o == $past(wr_data_i[ACFG_RX_CRC_BIT]))
      else $error("Mode write not stored.");

   a_reserved_zero: assert property (
      (global_settings & ~ACFG_CFG_MASK) == 16'h0000 &&
      (clock_and_channel_control & ~ACFG_CLOCK_MASK) == 16'h0000)
      else $error("Reserved bits not zero.");

   a_turbo_ratio: assert property (
      clock_and_channel_control[ACFG_TURBO_BIT] |=> oversampling_ratio_o == 15'h0040)
      else $error("Turbo ratio not 64.");

   // A clock write in the window retimes the divider, so such windows are excused.
   a_divide_two: assert property (
      (mod_clk_en_o && clock_and_channel_control[ACFG_DIV_LSB +: 2] == 2'b00 &&
       $stable(clock_and_channel_control) && !(wr_en_i && addr_i == ACFG_CLOCK_ADDR))
       |=> !mod_clk_en_o ##1
       (mod_clk_en_o || $past(wr_en_i && addr_i == ACFG_CLOCK_ADDR)))
      else $error("Divide by two spacing wrong.");

   a_gpo_follow: assert property (
      global_settings[ACFG_DIGITAL_OUT_ENABLE_BIT] |=> digital_out_oe_o &&
         digital_out_o == $past(global_settings[ACFG_DIGITAL_OUT_LEVEL_BIT]))
      else $error("Digital output not driven.");

   a_chop_short_wait: assert property (
      (chop_start_i && chop_enable_o && global_settings[ACFG_DLY_LSB +: 4] == 4'h0 &&
       !chop_busy) |=> chop_busy ##[1:40] chop_done_o)
      else $error("Chop delay did not end.");

endmodule

// ==== sim/acfg_host.sv ====
`timescale 1ns/1ps
module acfg_host
   import acfg_pkg::*;
(
   // Clock.
   input wire logic clk_i,
   // Strobes toward the block.
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [15:0] wr_data_o,
   // Read answer.
   input wire logic [15:0] rd_data_i,
   input wire logic rd_valid_i
);
   // Idle bus at time zero.
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wr_data_o = 16'h0000;
   end
   // One write; reserved bits and power codes are the caller's duty.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      wr_data_o = d;
      wr_en_o = 1'b1;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b0;
      wr_data_o = ~d; // Released data shows garbage.
   endtask
   // One read; the answer is taken the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_en_o = 1'b1;
      @(posedge clk_i);
      #1;
      rd_en_o = 1'b0;
      q = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
   endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import acfg_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wr, rd, rv, poe, men, cen, cd;
   logic cs = 1'b0;
   logic [7:0] ad;
   logic [15:0] wd, rdat, q;
   logic [2:0] cr = 3'h0;
   logic dr = 1'b0;
   logic [14:0] oversampling_ratio;
   logic [7:0] g0, g1, g2;
   logic [1:0] ws, pp;
   logic [2:0] ce;
   logic rce, xce, ans, rfc, toe, dout, doe, pin;
   int miscompares = 0;
   int total_checks = 0;
   always #12.5 clk = ~clk;
   acfg_host host (.clk_i(clk), .wr_en_o(wr), .rd_en_o(rd), .addr_o(ad),
      .wr_data_o(wd), .rd_data_i(rdat), .rd_valid_i(rv));
   acfg_regs DUT (.clk_i(clk), .resetn_i(rstn), .wr_en_i(wr), .rd_en_i(rd),
      .addr_i(ad), .wr_data_i(wd), .rd_data_o(rdat), .rd_valid_o(rv),
      .reg_crc_en_o(rce), .rx_crc_en_o(xce), .crc_ansi_o(ans),
      .reset_flag_clear_o(rfc), .word_size_select_o(ws), .timeout_en_o(toe),
      .channel_enable_o(ce), .mod_clk_en_o(men), .oversampling_ratio_o(oversampling_ratio),
      .power_profile_o(pp), .amp_gain_channel_zero_o(g0), .amp_gain_channel_one_o(g1),
      .amp_gain_channel_two_o(g2), .chop_start_i(cs), .chop_enable_o(cen),
      .chop_done_o(cd), .digital_out_o(dout), .digital_out_oe_o(doe),
      .chan_ready_i(cr), .data_read_i(dr), .data_ready_pin_o(pin),
      .data_ready_pin_oe_o(poe));
   // ---------------------------------------------------------------
   // Checking and closing.
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Reset values of every register and of the ratio, word size, timeout, CRC enable and power outputs.
   task automatic t_reset();
      host.rd(ACFG_MODE_ADDR, q); chk(q, 16'h0510);
      host.rd(ACFG_CLOCK_ADDR, q); chk(q, 16'h070e);
      host.rd(ACFG_GAIN_ADDR, q); chk(q, 16'h0000);
      host.rd(ACFG_CFG_ADDR, q); chk(q, 16'h0600);
      chk({1'b0, oversampling_ratio}, 16'h0400);
      chk({ws, toe, rce, xce}, 16'h000c);
      chk({14'h0000, pp}, 16'h0002);
   endtask
   // Mode bits drive their outputs; writing zero clears the flag.
   task automatic t_mode();
      host.wr(ACFG_MODE_ADDR, 16'h3f1f);
      chk({15'h0000, rfc}, 16'h0000);
      cyc(1);
      chk({rce, xce, ans, ws, toe}, 16'h003f);
      host.wr(ACFG_MODE_ADDR, 16'h0000);
      chk({15'h0000, rfc}, 16'h0001);
      cyc(1);
      chk({rce, xce, ans, ws, toe}, 16'h0000);
      host.wr(ACFG_MODE_ADDR, 16'hc0e0);
      host.rd(ACFG_MODE_ADDR, q); chk(q, 16'h0000);
   endtask
   // Every ratio code, then turbo; power code stays legal.
   task automatic t_ratio();
      for (int k = 0; k < 8; k++) begin
         host.wr(ACFG_CLOCK_ADDR, 16'h0002 | 16'(k << 2));
         cyc(2);
         chk({1'b0, oversampling_ratio}, 16'h0080 << k);
      end
      host.wr(ACFG_CLOCK_ADDR, 16'h023d);
      cyc(2);
      chk({1'b0, oversampling_ratio}, 16'h0040);
      chk({13'h0000, ce}, 16'h0002);
      chk({14'h0000, pp}, 16'h0001);
   endtask
   // Top gain code, an unmapped read and the digital output pin.
   task automatic t_gain_gpo();
      host.wr(ACFG_GAIN_ADDR, 16'h0701);
      host.wr(ACFG_CFG_ADDR, 16'h6000);
      cyc(2);
      chk({g2, g0}, 16'h8002);
      chk({g1, 6'h00, dout, doe}, 16'h0103);
      host.rd(8'h05, q); chk(q, 16'h0000);
   endtask
   // Level ready from any channel, clear by read, then idle float.
   task automatic t_ready();
      host.wr(ACFG_CLOCK_ADDR, 16'h070e);
      host.wr(ACFG_MODE_ADDR, 16'h0414);
      cr = 3'h4;
      cyc(1);
      cr = 3'h0;
      cyc(1);
      chk({14'h0000, pin, poe}, 16'h0001);
      cyc(3);
      chk({14'h0000, pin, poe}, 16'h0001);
      dr = 1'b1;
      cyc(1);
      dr = 1'b0;
      cyc(2);
      chk({14'h0000, pin, poe}, 16'h0003);
      host.wr(ACFG_MODE_ADDR, 16'h0416);
      cyc(2);
      chk({15'h0000, poe}, 16'h0000);
   endtask
   // A reset in mid-run brings back the reset-occurred bit and an idle pin.
   task automatic t_rerst();
      rstn = 1'b0;
      cyc(2);
      chk({14'h0000, pin, poe}, 16'h0003);
      rstn = 1'b1;
      host.rd(ACFG_MODE_ADDR, q);
      chk(q, 16'h0510);
   endtask
   // Divide by twelve: enable pulses stand twelve cycles apart.
   task automatic t_divider();
      int n;
      host.wr(ACFG_CLOCK_ADDR, 16'h07ce);
      n = 0;
      while (men !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      cyc(1);
      n = 1;
      while (men !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk(16'(n), 16'h000c);
   endtask
   // Counts modulator pulses from a chop start up to its done pulse.
   task automatic chop_run(output int n);
      int k;
      cs = 1'b1;
      cyc(1);
      cs = 1'b0;
      n = 0;
      k = 0;
      while (cd !== 1'b1 && k < 400) begin
         if (men === 1'b1) begin
            n++;
         end
         cyc(1);
         k++;
      end
   endtask
   // Chop off answers at once; chop on waits two to the code plus one periods.
   task automatic t_chop();
      int n;
      cs = 1'b1;
      cyc(1);
      cs = 1'b0;
      chk({14'h0000, cen, cd}, 16'h0001);
      host.wr(ACFG_CFG_ADDR, 16'h0100);
      chop_run(n);
      chk(16'(n), 16'h0002);
      host.wr(ACFG_CFG_ADDR, 16'h0700);
      chop_run(n);
      chk({15'h0000, cen}, 16'h0001);
      chk(16'(n), 16'h0010);
   endtask
   // Pulse format: one fixed low pulse for an arrival.
   task automatic t_pulse();
      int n;
      host.wr(ACFG_MODE_ADDR, 16'h0415);
      cr = 3'h1;
      cyc(1);
      cr = 3'h0;
      n = 0;
      repeat (6) begin
         if (pin === 1'b0) begin
            n++;
         end
         cyc(1);
      end
      chk(16'(n), 16'h0004);
   endtask
   // Lagging source waits for every enabled channel; leading takes the first.
   task automatic t_source();
      host.wr(ACFG_CLOCK_ADDR, 16'h050e);
      host.wr(ACFG_MODE_ADDR, 16'h0410);
      dr = 1'b1;
      cyc(1);
      dr = 1'b0;
      cr = 3'h3;
      cyc(1);
      cr = 3'h0;
      cyc(2);
      chk({15'h0000, pin}, 16'h0001);
      cr = 3'h4;
      cyc(1);
      cr = 3'h0;
      cyc(1);
      chk({15'h0000, pin}, 16'h0000);
      host.wr(ACFG_MODE_ADDR, 16'h0418);
      dr = 1'b1;
      cyc(1);
      dr = 1'b0;
      cyc(1);
      chk({15'h0000, pin}, 16'h0001);
      cr = 3'h1;
      cyc(1);
      cr = 3'h0;
      cyc(1);
      chk({15'h0000, pin}, 16'h0000);
   endtask
   // Watchdog: far beyond the few hundred cycles the run needs.
   initial begin
      #(25 * 20000);
      miscompares++;
      wrap_up();
   end
   // Main sequence.
   initial begin
      cyc(10);
      rstn = 1'b1;
      t_reset();
      t_mode();
      t_rerst();
      t_ratio();
      t_gain_gpo();
      t_chop();
      t_divider();
      t_ready();
      t_pulse();
      t_source();
      wrap_up();
   end
endmodule
